// File: hw/tpc_pkg.sv
package tpc_pkg;
   // Register byte offsets.
   localparam logic [7:0] TPC_OFF_TEST   = 8'hc7;
   localparam logic [7:0] TPC_OFF_STAT   = 8'hc8;
   localparam logic [7:0] TPC_OFF_ACTL   = 8'hc9;
   localparam logic [7:0] TPC_OFF_ADAT   = 8'hca;
   localparam logic [7:0] TPC_OFF_CFG    = 8'hcb;
   localparam logic [7:0] TPC_OFF_ENA    = 8'hcc;
   // Reset values and writable masks.
   localparam logic [7:0] TPC_RST_TEST   = 8'h00;
   localparam logic [7:0] TPC_RST_ACTL   = 8'h00;
   localparam logic [7:0] TPC_RST_ADAT   = 8'h00;
   localparam logic [7:0] TPC_RST_CFG    = 8'h80;
   localparam logic [7:0] TPC_RST_ENA    = 8'h00;
   localparam logic [7:0] TPC_MSK_TEST   = 8'h0f;
   localparam logic [7:0] TPC_MSK_ENA    = 8'h09;
   // Field positions.
   localparam int TPC_B_DIR    = 7;
   localparam int TPC_B_SNAP   = 7;
   localparam int TPC_B_GTRK   = 6;
   localparam int TPC_B_ZSUP   = 3;
   localparam int TPC_B_GSUB   = 0;
   localparam int TPC_B_START  = 0;
   localparam int TPC_B_PDIR   = 1;
   localparam int TPC_B_PMODE  = 2;
   localparam int TPC_B_PCE    = 0;
   localparam int TPC_B_SUB    = 5;
   localparam int TPC_B_TEST   = 6;
   localparam int TPC_B_STRK   = 4;
   // Table banks, selected by address bits 6:5.
   localparam logic [1:0] TPC_BANK_SUB   = 2'h0;
   localparam logic [1:0] TPC_BANK_TRK   = 2'h1;
   localparam logic [1:0] TPC_BANK_SIG   = 2'h2;
   // Replacement, suppression and pattern mode codes.
   typedef enum logic [2:0] {
      TPC_RP_NONE = 3'b000, TPC_RP_TRK = 3'b001, TPC_RP_ALAW = 3'b010,
      TPC_RP_ULAW = 3'b011, TPC_RP_LOOP = 3'b100
   } tpc_repl_t;
   typedef enum logic [2:0] {
      TPC_ZS_OFF = 3'b000, TPC_ZS_B8SIG = 3'b001, TPC_ZS_JAM8 = 3'b010,
      TPC_ZS_B7 = 3'b011, TPC_ZS_DDS = 3'b100
   } tpc_zsup_t;
   localparam logic [1:0] TPC_PM_ALL     = 2'b00;
   localparam logic [1:0] TPC_PM_BYTE    = 2'b01;
   localparam logic [1:0] TPC_PM_SEVEN   = 2'b10;
   localparam logic [7:0] TPC_DDS_CODE   = 8'h98;
   localparam logic [7:0] TPC_ALAW [0:7] = '{8'h34, 8'h21, 8'h21, 8'h34,
                                              8'hb4, 8'ha1, 8'ha1, 8'hb4};
   localparam logic [7:0] TPC_ULAW [0:7] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e,
                                              8'h9e, 8'h8b, 8'h8b, 8'h9e};
   // One channel slot of the transmit stream.
   typedef struct packed {
      logic       valid;
      logic [4:0] chan;
      logic       sig_frame;
      logic       mf_first;
      logic       mf_format;
      logic [3:0] sig;
      logic [7:0] data;
   } tpc_slot_t;
   typedef struct packed {
      logic       valid;
      logic [3:0] sig;
      logic [7:0] data;
   } tpc_out_t;
endpackage

// File: hw/tpc_top.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module tpc_top
   import tpc_pkg::*;
#(
   parameter int CHANNELS = 24
)
(
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output      logic [7:0]          reg_rdata,
   input  wire tpc_pkg::tpc_slot_t  slot_in,
   input  wire logic [7:0]          loopback_data,
   input  wire logic [7:0]          pattern_gen_data,
   output      tpc_pkg::tpc_out_t   slot_out,
   output      logic                pattern_check_valid,
   output      logic [7:0]          pattern_check_data,
   output      logic                pattern_check_seven,
   output      logic                pattern_direction,
   output      logic [1:0]          pattern_extract_mode,
   output      logic                pattern_test_start
);
   import tpc_pkg::*;

   if (CHANNELS < 1 || CHANNELS > 24)
   begin : g_bad
      $error("CHANNELS must lie between 1 and 24.");
   end

   logic [7:0] test_q;
   logic [7:0] actl_q;
   logic [7:0] adat_q;
   logic [7:0] cfg_q;
   logic [7:0] ena_q;
   logic       busy_q;
   logic [7:0] rdata_q;
   logic       start_prev_q;
   logic       start_q;
   logic [2:0] phase_q;
   logic [7:0] sub_mem [0:CHANNELS-1];
   logic [7:0] trk_mem [0:CHANNELS-1];
   logic [7:0] sig_mem [0:CHANNELS-1];
   logic [3:0] snap_mem [0:CHANNELS-1];
   tpc_out_t   out_q;
   logic       chk_valid_q;
   logic [7:0] chk_data_q;

   // Indirect table address decode.
   logic [1:0] t_bank;
   logic [4:0] t_idx;
   logic       t_ok;
   assign t_bank = actl_q[6:5];
   assign t_idx  = actl_q[4:0] - 5'h01;
   assign t_ok   = (actl_q[4:0] != 5'h00) && (32'(actl_q[4:0]) <= CHANNELS)
                   && (t_bank != 2'h3);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         test_q <= TPC_RST_TEST;
         cfg_q  <= TPC_RST_CFG;
         ena_q  <= TPC_RST_ENA;
      end
      else if (reg_wr)
      begin
         if (reg_addr == TPC_OFF_TEST)
            test_q <= reg_wdata & TPC_MSK_TEST;
         if (reg_addr == TPC_OFF_CFG)
            cfg_q <= reg_wdata;
         if (reg_addr == TPC_OFF_ENA)
            ena_q <= reg_wdata & TPC_MSK_ENA;
      end
   end

   // A control write made while busy is dropped, so a pending access
   // is never redirected halfway.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         actl_q <= TPC_RST_ACTL;
         busy_q <= 1'b0;
      end
      else if (reg_wr && reg_addr == TPC_OFF_ACTL && !busy_q)
      begin
         actl_q <= reg_wdata;
         busy_q <= 1'b1;
      end
      else
      begin
         busy_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         adat_q <= TPC_RST_ADAT;
      else if (busy_q && actl_q[TPC_B_DIR])
      begin
         adat_q <= 8'h00;
         if (t_ok)
         begin
            case (t_bank)
               TPC_BANK_SUB: adat_q <= sub_mem[t_idx];
               TPC_BANK_TRK: adat_q <= trk_mem[t_idx];
               default:      adat_q <= sig_mem[t_idx];
            endcase
         end
      end
      else if (reg_wr && reg_addr == TPC_OFF_ADAT)
         adat_q <= reg_wdata;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            sub_mem[i] <= 8'h00;
            trk_mem[i] <= 8'h00;
            sig_mem[i] <= 8'h00;
         end
      end
      else if (busy_q && !actl_q[TPC_B_DIR] && t_ok)
      begin
         case (t_bank)
            TPC_BANK_SUB: sub_mem[t_idx] <= adat_q;
            TPC_BANK_TRK: trk_mem[t_idx] <= adat_q;
            default:      sig_mem[t_idx] <= adat_q;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            TPC_OFF_TEST: rdata_q <= test_q;
            TPC_OFF_STAT: rdata_q <= {7'h00, busy_q};
            TPC_OFF_ACTL: rdata_q <= actl_q;
            TPC_OFF_ADAT: rdata_q <= adat_q;
            TPC_OFF_CFG:  rdata_q <= cfg_q;
            TPC_OFF_ENA:  rdata_q <= ena_q;
            default:      rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end
   assign reg_rdata = rdata_q;

   // The start pulse is taken from the stored bit, so holding it high
   // never restarts the pattern logic.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         start_prev_q <= 1'b0;
         start_q      <= 1'b0;
      end
      else
      begin
         start_prev_q <= test_q[TPC_B_START];
         start_q      <= test_q[TPC_B_START] && !start_prev_q;
      end
   end
   assign pattern_test_start   = start_q;
   assign pattern_direction    = test_q[TPC_B_PDIR];
   assign pattern_extract_mode = test_q[TPC_B_PMODE +: 2];

   // Slot decode and per-channel table lookup.
   logic       pce;
   logic       ch_ok;
   logic [4:0] ch;
   logic [7:0] sub_e;
   logic [7:0] trk_e;
   logic [7:0] sig_e;
   logic [3:0] snap_e;
   assign pce    = ena_q[TPC_B_PCE];
   assign ch_ok  = slot_in.valid && (32'(slot_in.chan) < CHANNELS);
   assign ch     = ch_ok ? slot_in.chan : 5'h00;
   assign sub_e  = sub_mem[ch];
   assign trk_e  = trk_mem[ch];
   assign sig_e  = sig_mem[ch];
   assign snap_e = snap_mem[ch];

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         phase_q <= 3'h0;
      else if (ch_ok && 32'(slot_in.chan) == CHANNELS - 1)
         phase_q <= phase_q + 3'h1;
   end

   // Snapshot keeps the first frame's bits for the whole multiframe.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < CHANNELS; i++)
            snap_mem[i] <= 4'h0;
      end
      else if (ch_ok && slot_in.mf_first)
         snap_mem[ch] <= slot_in.sig;
   end

   tpc_repl_t  rsel;
   tpc_zsup_t  zsel;
   logic [7:0] d_rep;
   logic [7:0] d_zsup;
   logic [7:0] d_fin;
   logic [3:0] s_fin;
   logic       tested;
   logic       pm_ok;

   always_comb
   begin
      if (cfg_q[TPC_B_GSUB +: 3] == 3'b000)
         rsel = tpc_repl_t'(sub_e[TPC_B_SUB +: 3]);
      else
         rsel = tpc_repl_t'(cfg_q[TPC_B_GSUB +: 3]);
      case (rsel)
         TPC_RP_TRK:  d_rep = trk_e;
         TPC_RP_ALAW: d_rep = TPC_ALAW[phase_q];
         TPC_RP_ULAW: d_rep = TPC_ULAW[phase_q];
         TPC_RP_LOOP: d_rep = loopback_data;
         default:     d_rep = slot_in.data;
      endcase
   end

   // Reserved suppression codes leave the byte alone.
   always_comb
   begin
      zsel   = tpc_zsup_t'(cfg_q[TPC_B_ZSUP +: 3]);
      d_zsup = d_rep;
      case (zsel)
         TPC_ZS_B8SIG:
         begin
            if (d_rep == 8'h00)
               d_zsup = slot_in.sig_frame ? 8'h02 : 8'h01;
         end
         TPC_ZS_JAM8:
            d_zsup = d_rep | 8'h01;
         TPC_ZS_B7:
         begin
            if (d_rep == 8'h00)
               d_zsup = 8'h02;
         end
         TPC_ZS_DDS:
         begin
            if (d_rep == 8'h00)
               d_zsup = TPC_DDS_CODE;
         end
         default:
            d_zsup = d_rep;
      endcase
   end

   // Bit 8 is the last bit on the line, so it sits in bit 0 here.
   always_comb
   begin
      pm_ok  = pattern_extract_mode != 2'b11;
      tested = pm_ok && (pattern_extract_mode == TPC_PM_ALL
                         || sig_e[TPC_B_TEST]);
      d_fin  = d_zsup;
      if (tested && !pattern_direction)
      begin
         if (pattern_extract_mode == TPC_PM_SEVEN)
            d_fin = {pattern_gen_data[7:1], d_zsup[0]};
         else
            d_fin = pattern_gen_data;
      end
      if (global_trk() || sig_e[TPC_B_STRK])
         s_fin = sig_e[3:0];
      else if (cfg_q[TPC_B_SNAP] && slot_in.mf_format && !slot_in.mf_first)
         s_fin = snap_e;
      else
         s_fin = slot_in.sig;
   end

   function automatic logic global_trk();
      return cfg_q[TPC_B_GTRK];
   endfunction

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         out_q <= '0;
      else
      begin
         out_q.valid <= slot_in.valid;
         out_q.data  <= (pce && ch_ok) ? d_fin : slot_in.data;
         out_q.sig   <= (pce && ch_ok) ? s_fin : slot_in.sig;
      end
   end
   assign slot_out = out_q;

   // Checking in the transmit path taps the incoming payload byte.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         chk_valid_q <= 1'b0;
         chk_data_q  <= 8'h00;
      end
      else
      begin
         chk_valid_q <= pce && ch_ok && tested && pattern_direction;
         chk_data_q  <= slot_in.data;
      end
   end
   assign pattern_check_valid = chk_valid_q;
   assign pattern_check_data  = chk_data_q;
   assign pattern_check_seven = pattern_extract_mode == TPC_PM_SEVEN;
endmodule

// File: bench/tpc_props.sv
`timescale 1ns/100ps
module tpc_props
(
   input wire logic               core_clk,
   input wire logic               rstn,
   input wire logic [7:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire logic [7:0]         reg_rdata,
   input wire tpc_pkg::tpc_slot_t slot_in,
   input wire tpc_pkg::tpc_out_t  slot_out,
   input wire logic               pattern_check_seven,
   input wire logic               pattern_direction,
   input wire logic [1:0]         pattern_extract_mode,
   input wire logic               pattern_test_start
);
   import tpc_pkg::*;
   logic       ena_q;
   logic [3:0] test_q;
   logic       actl_q;
   // Shadow copies of the enable and test registers, taken from the bus alone.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ena_q  <= 1'b0;
         test_q <= 4'h0;
         actl_q <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == TPC_OFF_ENA)
            ena_q <= reg_wdata[0];
         if (reg_wr && reg_addr == TPC_OFF_TEST)
            test_q <= reg_wdata[3:0];
         actl_q <= reg_wr && reg_addr == TPC_OFF_ACTL;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_rdata_quiet: assert property (
      reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("read data without read");
   a_out_valid: assert property (
      slot_out.valid == $past(slot_in.valid)) else $error("slot latency wrong");
   a_pass_off: assert property (
      slot_in.valid && !ena_q |=> slot_out.data == $past(slot_in.data)
      && slot_out.sig == $past(slot_in.sig)) else $error("disabled slot altered");
   a_busy_set: assert property (
      reg_wr && reg_addr == TPC_OFF_ACTL && !actl_q ##1 reg_rd && reg_addr == TPC_OFF_STAT
      |=> reg_rdata == 8'h01) else $error("busy not raised");
   a_busy_clear: assert property (
      reg_wr && reg_addr == TPC_OFF_ACTL && !actl_q ##2 reg_rd && reg_addr == TPC_OFF_STAT
      |=> reg_rdata == 8'h00) else $error("busy not cleared");
   a_start_edge: assert property (
      reg_wr && reg_addr == TPC_OFF_TEST && reg_wdata[0] && !test_q[0]
      |=> ##1 pattern_test_start) else $error("start pulse missing");
   a_start_level: assert property (
      reg_wr && reg_addr == TPC_OFF_TEST && reg_wdata[0] && test_q[0]
      |=> ##1 !pattern_test_start) else $error("start on level");
   a_mode_follow: assert property (
      pattern_extract_mode == test_q[3:2] && pattern_direction == test_q[1]
      && pattern_check_seven == (test_q[3:2] == 2'b10)) else $error("mode outputs wrong");
endmodule
bind tpc_top tpc_props i_props (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .slot_in(slot_in), .slot_out(slot_out), .pattern_check_seven(pattern_check_seven),
   .pattern_direction(pattern_direction), .pattern_extract_mode(pattern_extract_mode),
   .pattern_test_start(pattern_test_start));

// File: bench/tpc_frame_src.sv
`timescale 1ns/100ps
module tpc_frame_src
(
   input  wire logic               core_clk,
   input  wire logic               rstn,
   input  wire tpc_pkg::tpc_slot_t nxt,
   output      tpc_pkg::tpc_slot_t slot_in,
   output      logic [7:0]         loopback_data,
   output      logic [7:0]         pattern_gen_data
);
   import tpc_pkg::*;
   // Between slots the slot data and pattern_gen_data lines keep toggling, while loopback_data holds, so stale bytes never look valid.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         slot_in          <= '0;
         loopback_data    <= 8'h00;
         pattern_gen_data <= 8'h00;
      end
      else if (nxt.valid)
      begin
         slot_in          <= nxt;
         loopback_data    <= {nxt.data[3:0], nxt.data[7:4]};
         pattern_gen_data <= ~nxt.data;
      end
      else
      begin
         slot_in.valid    <= 1'b0;
         slot_in.data     <= ~slot_in.data;
         pattern_gen_data <= ~pattern_gen_data;
      end
   end
endmodule

// File: bench/tb_transmit_payload_control.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_transmit_payload_control;
   import tpc_pkg::*;
   logic       core_clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata, loopback_data, pattern_gen_data, pattern_check_data;
   tpc_slot_t  slot_in;
   tpc_slot_t  nxt = '0;
   tpc_out_t   slot_out;
   logic       pattern_check_valid, pattern_check_seven, pattern_direction, pattern_test_start;
   logic [1:0] pattern_extract_mode;
   int         miscompares = 0;
   int         total_checks = 0;
   int         starts = 0;
   logic [7:0] zx [5] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h98};
   logic [7:0] rx [5] = '{8'h5a, 8'h5a, 8'h34, 8'h1e, 8'h53};
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (pattern_test_start === 1'b1)
         starts++;
   tpc_frame_src i_src (.core_clk(core_clk), .rstn(rstn), .nxt(nxt), .slot_in(slot_in),
      .loopback_data(loopback_data), .pattern_gen_data(pattern_gen_data));
   tpc_top i_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_in(slot_in),
      .loopback_data(loopback_data), .pattern_gen_data(pattern_gen_data),
      .slot_out(slot_out), .pattern_check_valid(pattern_check_valid),
      .pattern_check_data(pattern_check_data), .pattern_check_seven(pattern_check_seven),
      .pattern_direction(pattern_direction), .pattern_extract_mode(pattern_extract_mode),
      .pattern_test_start(pattern_test_start));
   task results;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 `CHK("reg_rdata", e, reg_rdata)
   endtask
   // Status is polled right behind the control write, the hardest case for busy.
   task ind(input logic [7:0] a);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= TPC_OFF_ACTL;
      reg_wdata <= a;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= TPC_OFF_STAT;
      @(posedge core_clk);
      #1 `CHK("busy", 8'h01, reg_rdata)
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 `CHK("idle", 8'h00, reg_rdata)
   endtask
   task send(input logic [4:0] c, input logic [2:0] f, input logic [3:0] s,
             input logic [7:0] d, input logic [7:0] ed, input logic [3:0] es);
      @(posedge core_clk);
      nxt <= {1'b1, c, f, s, d};
      @(posedge core_clk);
      nxt.valid <= 1'b0;
      @(posedge core_clk);
      #1 `CHK("data", ed, slot_out.data)
      `CHK("sig", es, slot_out.sig)
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      results;
   end
   initial
   begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      rd(TPC_OFF_TEST, 8'h00);
      rd(TPC_OFF_STAT, 8'h00);
      rd(TPC_OFF_ACTL, 8'h00);
      rd(TPC_OFF_ADAT, 8'h00);
      rd(TPC_OFF_CFG, 8'h80);
      rd(TPC_OFF_ENA, 8'h00);
      rd(8'hc6, 8'h00);
      wr(TPC_OFF_STAT, 8'hff);
      rd(TPC_OFF_STAT, 8'h00);
      wr(TPC_OFF_TEST, 8'hff);
      wr(TPC_OFF_TEST, 8'hff);
      rd(TPC_OFF_TEST, 8'h0f);
      `CHK("starts", 1, starts)
      wr(TPC_OFF_ADAT, 8'h20);
      ind(8'h01);
      wr(TPC_OFF_ADAT, 8'h5a);
      ind(8'h21);
      ind(8'h41);
      wr(TPC_OFF_ADAT, 8'h03);
      ind(8'h42);
      ind(8'ha1);
      rd(TPC_OFF_ADAT, 8'h5a);
      ind(8'h99);
      rd(TPC_OFF_ADAT, 8'h00);
      wr(TPC_OFF_CFG, 8'h10);
      send(5, 3'b000, 4'h0, 8'h00, 8'h00, 4'h0);
      wr(TPC_OFF_ENA, 8'hff);
      rd(TPC_OFF_ENA, 8'h09);
      for (int i = 0; i < 5; i++)
      begin
         wr(TPC_OFF_CFG, 8'(i << 3));
         send(5, 3'b000, 4'h0, 8'h00, zx[i], 4'h0);
      end
      wr(TPC_OFF_CFG, 8'h08);
      send(5, 3'b100, 4'h0, 8'h00, 8'h02, 4'h0);
      wr(TPC_OFF_CFG, 8'h10);
      send(5, 3'b000, 4'h0, 8'h10, 8'h11, 4'h0);
      wr(TPC_OFF_CFG, 8'h18);
      send(5, 3'b000, 4'h0, 8'h10, 8'h10, 4'h0);
      for (int g = 0; g < 5; g++)
      begin
         wr(TPC_OFF_CFG, 8'(g));
         send(0, 3'b000, 4'h0, 8'h35, rx[g], 4'ha);
      end
      wr(TPC_OFF_CFG, 8'h00);
      send(1, 3'b000, 4'h5, 8'h35, 8'h35, 4'h5);
      wr(TPC_OFF_CFG, 8'h40);
      send(1, 3'b000, 4'h5, 8'h35, 8'h35, 4'h3);
      wr(TPC_OFF_CFG, 8'h80);
      send(1, 3'b011, 4'h6, 8'h35, 8'h35, 4'h6);
      send(1, 3'b001, 4'h9, 8'h35, 8'h35, 4'h6);
      wr(TPC_OFF_CFG, 8'h00);
      send(1, 3'b001, 4'h9, 8'h35, 8'h35, 4'h9);
      wr(TPC_OFF_TEST, 8'h00);
      wr(TPC_OFF_TEST, 8'h01);
      send(1, 3'b000, 4'h5, 8'h35, 8'hca, 4'h5);
      `CHK("chk_off", 1'b0, pattern_check_valid)
      wr(TPC_OFF_TEST, 8'h04);
      wr(TPC_OFF_TEST, 8'h05);
      send(0, 3'b000, 4'h0, 8'h35, 8'hca, 4'ha);
      send(1, 3'b000, 4'h5, 8'h35, 8'h35, 4'h5);
      wr(TPC_OFF_TEST, 8'h08);
      wr(TPC_OFF_TEST, 8'h09);
      send(0, 3'b000, 4'h0, 8'h34, 8'hca, 4'ha);
      wr(TPC_OFF_TEST, 8'h02);
      wr(TPC_OFF_TEST, 8'h03);
      send(1, 3'b000, 4'h5, 8'h35, 8'h35, 4'h5);
      `CHK("chk_valid", 1'b1, pattern_check_valid)
      `CHK("chk_data", 8'h35, pattern_check_data)
      `CHK("starts", 5, starts)
      results;
   end
endmodule
